// file: pkg/psf_flag_if.sv
// Carrier between the register top and the sticky flag store
`timescale 1ns/1ps
`default_nettype none
interface psf_flag_if;
    logic [15:0] set;
    logic        clr;
    logic [15:0] flags;
    modport owner (output set, output clr, input flags);
    modport store (input set, input clr, output flags);
endinterface : psf_flag_if
`default_nettype wire

// file: pkg/psf_pkg.sv
// Constants for the PHY vendor status and fast-mode control registers
`default_nettype none
package psf_pkg;
    // ----------------------------------------
    // Register addresses
    // ----------------------------------------
    localparam logic [4:0]  PSF_ADDR_STATUS = 5'h1C;
    localparam logic [4:0]  PSF_ADDR_CTRL   = 5'h1D;
    // ----------------------------------------
    // Status field positions
    // ----------------------------------------
    localparam int unsigned PSF_ST_SFD      = 8;
    localparam int unsigned PSF_ST_MANCH    = 7;
    localparam int unsigned PSF_ST_POL      = 6;
    localparam int unsigned PSF_ST_DISC     = 5;
    localparam int unsigned PSF_ST_LOCK     = 4;
    localparam int unsigned PSF_ST_FCAR     = 3;
    localparam int unsigned PSF_ST_JAM      = 2;
    localparam int unsigned PSF_ST_UP100    = 1;
    localparam int unsigned PSF_ST_UP10     = 0;
    localparam logic [15:0] PSF_STICKY_MASK = 16'h01BC;
    localparam logic [15:0] PSF_STATUS_RST  = 16'h0000;
    // ----------------------------------------
    // Control field positions and reset
    // ----------------------------------------
    localparam int unsigned PSF_CT_SOFTRST  = 15;
    localparam int unsigned PSF_CT_FRST_A   = 14;
    localparam int unsigned PSF_CT_FRST_B   = 13;
    localparam int unsigned PSF_CT_TXON     = 12;
    localparam int unsigned PSF_CT_LED      = 11;
    localparam int unsigned PSF_CT_CRSSEL   = 10;
    localparam int unsigned PSF_CT_LINKERR  = 9;
    localparam int unsigned PSF_CT_PKTERR   = 8;
    localparam int unsigned PSF_CT_STRETCH  = 7;
    localparam int unsigned PSF_CT_CODEC    = 6;
    localparam int unsigned PSF_CT_ALIGN    = 5;
    localparam int unsigned PSF_CT_SCRAM    = 4;
    localparam int unsigned PSF_CT_CARIN    = 3;
    localparam int unsigned PSF_CT_JAM      = 2;
    localparam int unsigned PSF_CT_FEF      = 1;
    localparam int unsigned PSF_CT_FIBER    = 0;
    localparam logic [15:0] PSF_CTRL_RST    = 16'h1000;
    localparam logic [15:0] PSF_CTRL_WMASK  = 16'h7FFF;
    // ----------------------------------------
    // Receive error codes on the nibble lines
    // ----------------------------------------
    localparam logic [3:0]  PSF_CODE_MANCH  = 4'h1;
    localparam logic [3:0]  PSF_CODE_LINK   = 4'h2;
    localparam logic [3:0]  PSF_CODE_PKT    = 4'h3;
    // ----------------------------------------
    // Pulse stretch timing
    // ----------------------------------------
    localparam int          PSF_STRETCH_NS  = 42000000;
    localparam int          PSF_CLK_NS      = 8;
    localparam int          PSF_STRETCH_CYC = (PSF_STRETCH_NS + PSF_CLK_NS - 1) / PSF_CLK_NS;
    localparam int          PSF_STR_W       = 23;
endpackage : psf_pkg
`default_nettype wire

// file: src/psf_flag_store.sv
// Sticky status flags, cleared by read or soft reset
`timescale 1ns/1ps
`default_nettype none
module psf_flag_store
    import psf_pkg::*;
(
    input  wire logic    core_clk,
    input  wire logic    rst_b,
    psf_flag_if.store    fb
);
    // ----------------------------------------
    // Flag storage, a set beats a clear
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            fb.flags <= PSF_STATUS_RST;
        end else if (fb.clr) begin
            fb.flags <= fb.set & PSF_STICKY_MASK;
        end else begin
            fb.flags <= (fb.flags | fb.set) & PSF_STICKY_MASK;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_set_wins;
        @(posedge core_clk) disable iff (!rst_b)
        (fb.set[PSF_ST_DISC] && fb.clr) |=> fb.flags[PSF_ST_DISC];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("disconnect event lost during clear");
endmodule : psf_flag_store
`default_nettype wire

// file: src/psf_phy_regs.sv
// Vendor status and fast-mode control registers with their pin effects
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - 10M: missing SFD sets sticky flag
// - 10M: Manchester error sets flag, drives code
// - 10M: live bit, reversed polarity found and corrected
// - 100M: disconnect latches until read
// - 100M: scrambler lost lock latches until read
// - 100M: false carrier latches until read
// - 100M: forced jam latches until read
// - Live link-up bits for 100M and 10M
// - Soft reset bit restores defaults, self-clears
// - Transmitter off: pos low, neg high
// - LED flashing from bit or pin
// - Carrier sense on receive only when selected
// - Link error code on nibble with error
// - Packet error code when scrambler unlocked
// - Stretch status outputs when enabled
// - Codec bypass from bit or pin
// - Aligner bypass from bit
// - Scrambler bypass from bit or pin
// - Carrier integrity from bit or pin
// - Integrity jam ORed into collision output
// - Far-end fault enable, software uses carefully
// - Fiber mode from bit or pin
// - Autopolarity off blocks polarity correction
module psf_phy_regs
    import psf_pkg::*;
#(
    parameter int STRETCH_CYCLES = PSF_STRETCH_CYC
) (
    input  wire logic        core_clk,
    input  wire logic        rst_b,
    input  wire logic [4:0]  mgmt_addr,
    input  wire logic        mgmt_wr_en,
    input  wire logic        mgmt_rd_en,
    input  wire logic [15:0] mgmt_wdata,
    output logic      [15:0] mgmt_rdata,
    output logic             mgmt_soft_reset,
    input  wire logic        speed_100,
    input  wire logic        sfd_missing_evt,
    input  wire logic        manchester_viol_evt,
    input  wire logic        polarity_reversed,
    input  wire logic        autopolarity_off,
    input  wire logic        disconnect_evt,
    input  wire logic        lock_lost_evt,
    input  wire logic        false_carrier_evt,
    input  wire logic        jam_forced_evt,
    input  wire logic        fast_xcvr_ok,
    input  wire logic        slow_xcvr_ok,
    input  wire logic [3:0]  rx_nibble_in,
    input  wire logic        rx_err_in,
    input  wire logic        link_fault_in,
    input  wire logic        scrambler_locked,
    output logic      [3:0]  mii_rx_nibble,
    output logic             mii_rx_error,
    output logic             polarity_correct,
    input  wire logic        tx_pos_in,
    input  wire logic        tx_neg_in,
    output logic             twisted_pair_pos,
    output logic             twisted_pair_neg,
    input  wire logic        led_flash_pin,
    output logic             led_flash_on,
    input  wire logic        carrier_sense_sel_pin,
    input  wire logic        rx_active,
    input  wire logic        tx_active,
    output logic             mii_carrier_sense_out,
    input  wire logic        col_in,
    input  wire logic        carrier_jam_in,
    output logic             collision_carrier_out,
    input  wire logic [2:0]  status_in,
    output logic      [2:0]  status_out,
    input  wire logic        codec_bypass_pin,
    output logic             codec_bypass,
    output logic             aligner_bypass,
    input  wire logic        scrambler_bypass_pin,
    output logic             scrambler_bypass,
    input  wire logic        carrier_integrity_pin,
    output logic             carrier_integrity_en,
    output logic             far_fault_en,
    input  wire logic        fiber_mode_pin,
    output logic             fiber_mode,
    output logic             factory_reset_a,
    output logic             factory_reset_b
);
    // ----------------------------------------
    // Decode
    // ----------------------------------------
    logic [15:0] ctrl_reg;
    logic        pol_fixed_reg;
    logic        up100_reg;
    logic        up10_reg;
    logic [15:0] status_word;
    logic        wr_ctrl;
    logic        rd_status;
    logic        soft_rst;
    logic        integ_on;

    function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
        return a == r;
    endfunction : hit

    assign wr_ctrl   = mgmt_wr_en && hit(mgmt_addr, PSF_ADDR_CTRL);
    assign rd_status = mgmt_rd_en && hit(mgmt_addr, PSF_ADDR_STATUS);
    assign soft_rst  = wr_ctrl && mgmt_wdata[PSF_CT_SOFTRST];
    assign integ_on  = ctrl_reg[PSF_CT_CARIN] | carrier_integrity_pin;

    // ----------------------------------------
    // Sticky flags
    // ----------------------------------------
    psf_flag_if flag_bus ();

    always_comb begin
        flag_bus.set = 16'h0000;
        flag_bus.set[PSF_ST_SFD]   = sfd_missing_evt && !speed_100;
        flag_bus.set[PSF_ST_MANCH] = manchester_viol_evt && !speed_100;
        flag_bus.set[PSF_ST_DISC]  = disconnect_evt && speed_100;
        flag_bus.set[PSF_ST_LOCK]  = lock_lost_evt && speed_100;
        flag_bus.set[PSF_ST_FCAR]  = false_carrier_evt && speed_100;
        flag_bus.set[PSF_ST_JAM]   = jam_forced_evt && speed_100;
    end

    assign flag_bus.clr = rd_status || soft_rst;

    psf_flag_store u_flags (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .fb       (flag_bus.store)
    );

    // ----------------------------------------
    // Live status bits
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pol_fixed_reg    <= 1'b0;
            polarity_correct <= 1'b0;
            up100_reg        <= 1'b0;
            up10_reg         <= 1'b0;
        end else begin
            pol_fixed_reg    <= polarity_reversed && !autopolarity_off && !speed_100;
            polarity_correct <= polarity_reversed && !autopolarity_off && !speed_100;
            up100_reg        <= fast_xcvr_ok;
            up10_reg         <= slow_xcvr_ok;
        end
    end

    always_comb begin
        status_word = flag_bus.flags & PSF_STICKY_MASK;
        status_word[PSF_ST_POL]   = pol_fixed_reg;
        status_word[PSF_ST_UP100] = up100_reg;
        status_word[PSF_ST_UP10]  = up10_reg;
    end

    // ----------------------------------------
    // Control register
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg        <= PSF_CTRL_RST;
            mgmt_soft_reset <= 1'b0;
        end else begin
            mgmt_soft_reset <= soft_rst;
            if (soft_rst) begin
                ctrl_reg <= PSF_CTRL_RST;
            end else if (wr_ctrl) begin
                ctrl_reg <= mgmt_wdata & PSF_CTRL_WMASK;
            end
        end
    end

    // ----------------------------------------
    // Read port
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mgmt_rdata <= 16'h0000;
        end else if (mgmt_rd_en) begin
            if (hit(mgmt_addr, PSF_ADDR_STATUS)) begin
                mgmt_rdata <= status_word;
            end else if (hit(mgmt_addr, PSF_ADDR_CTRL)) begin
                mgmt_rdata <= ctrl_reg & PSF_CTRL_WMASK;
            end else begin
                mgmt_rdata <= 16'h0000;
            end
        end
    end

    // ----------------------------------------
    // Receive nibble error codes
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mii_rx_nibble <= 4'h0;
            mii_rx_error  <= 1'b0;
        end else if (!speed_100 && manchester_viol_evt) begin
            mii_rx_nibble <= PSF_CODE_MANCH;
            mii_rx_error  <= 1'b1;
        end else if (speed_100 && rx_err_in && ctrl_reg[PSF_CT_LINKERR] && link_fault_in) begin
            mii_rx_nibble <= PSF_CODE_LINK;
            mii_rx_error  <= 1'b1;
        end else if (speed_100 && rx_err_in && ctrl_reg[PSF_CT_PKTERR] && !scrambler_locked) begin
            mii_rx_nibble <= PSF_CODE_PKT;
            mii_rx_error  <= 1'b1;
        end else begin
            mii_rx_nibble <= rx_nibble_in;
            mii_rx_error  <= rx_err_in;
        end
    end

    // ----------------------------------------
    // Line and MII side effects
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            twisted_pair_pos      <= 1'b0;
            twisted_pair_neg      <= 1'b0;
            mii_carrier_sense_out <= 1'b0;
            collision_carrier_out <= 1'b0;
        end else begin
            twisted_pair_pos      <= ctrl_reg[PSF_CT_TXON] ? tx_pos_in : 1'b0;
            twisted_pair_neg      <= ctrl_reg[PSF_CT_TXON] ? tx_neg_in : 1'b1;
            mii_carrier_sense_out <= rx_active ||
                                     (tx_active && !(ctrl_reg[PSF_CT_CRSSEL] || carrier_sense_sel_pin));
            collision_carrier_out <= col_in ||
                                     (ctrl_reg[PSF_CT_JAM] && integ_on && carrier_jam_in);
        end
    end

    // ----------------------------------------
    // Mode outputs
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            led_flash_on         <= 1'b0;
            codec_bypass         <= 1'b0;
            aligner_bypass       <= 1'b0;
            scrambler_bypass     <= 1'b0;
            carrier_integrity_en <= 1'b0;
            far_fault_en         <= 1'b0;
            fiber_mode           <= 1'b0;
            factory_reset_a      <= 1'b0;
            factory_reset_b      <= 1'b0;
        end else begin
            led_flash_on         <= ctrl_reg[PSF_CT_LED] || led_flash_pin;
            codec_bypass         <= ctrl_reg[PSF_CT_CODEC] || codec_bypass_pin;
            aligner_bypass       <= ctrl_reg[PSF_CT_ALIGN];
            scrambler_bypass     <= ctrl_reg[PSF_CT_SCRAM] || scrambler_bypass_pin;
            carrier_integrity_en <= integ_on;
            far_fault_en         <= ctrl_reg[PSF_CT_FEF];
            fiber_mode           <= ctrl_reg[PSF_CT_FIBER] || fiber_mode_pin;
            factory_reset_a      <= ctrl_reg[PSF_CT_FRST_A];
            factory_reset_b      <= ctrl_reg[PSF_CT_FRST_B];
        end
    end

    // ----------------------------------------
    // Status stretching
    // ----------------------------------------
    psf_stretch #(
        .CYCLES (STRETCH_CYCLES)
    ) u_stretch (
        .core_clk (core_clk),
        .rst_b    (rst_b),
        .enable   (ctrl_reg[PSF_CT_STRETCH]),
        .din      (status_in),
        .dout     (status_out)
    );

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_sfd_flag;
        (sfd_missing_evt && !speed_100) |=> flag_bus.flags[PSF_ST_SFD];
    endproperty
    a_sfd_flag: assert property (p_sfd_flag)
        else $error("missing SFD flag not set");

    property p_manch_code;
        (manchester_viol_evt && !speed_100) |=> (mii_rx_nibble == PSF_CODE_MANCH) && mii_rx_error
            && flag_bus.flags[PSF_ST_MANCH];
    endproperty
    a_manch_code: assert property (p_manch_code)
        else $error("code violation not reported");

    property p_lock_hold;
        flag_bus.flags[PSF_ST_LOCK] && !flag_bus.clr |=> flag_bus.flags[PSF_ST_LOCK];
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("lost-lock flag dropped without read");

    property p_read_clear;
        (rd_status && flag_bus.set == 16'h0000) |=> (flag_bus.flags == 16'h0000)
            && (mgmt_rdata[15:9] == 7'h00);
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status read did not clear flags");

    property p_soft_reset;
        soft_rst |=> (ctrl_reg == PSF_CTRL_RST) && mgmt_soft_reset ##1 (mgmt_soft_reset == $past(soft_rst));
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not restore defaults");

    property p_tx_off;
        !ctrl_reg[PSF_CT_TXON] |=> !twisted_pair_pos && twisted_pair_neg;
    endproperty
    a_tx_off: assert property (p_tx_off)
        else $error("transmitter not forced off");

    property p_led;
        (ctrl_reg[PSF_CT_LED] || led_flash_pin) |=> led_flash_on;
    endproperty
    a_led: assert property (p_led)
        else $error("LED flashing not enabled");

    property p_crs_rx_only;
        ((ctrl_reg[PSF_CT_CRSSEL] || carrier_sense_sel_pin) && tx_active && !rx_active)
            |=> !mii_carrier_sense_out;
    endproperty
    a_crs_rx_only: assert property (p_crs_rx_only)
        else $error("carrier sense raised on transmit");

    property p_link_code;
        (speed_100 && rx_err_in && ctrl_reg[PSF_CT_LINKERR] && link_fault_in)
            |=> (mii_rx_nibble == PSF_CODE_LINK) && mii_rx_error;
    endproperty
    a_link_code: assert property (p_link_code)
        else $error("link error code missing");

    property p_jam_or;
        (ctrl_reg[PSF_CT_JAM] && integ_on && carrier_jam_in) |=> collision_carrier_out;
    endproperty
    a_jam_or: assert property (p_jam_or)
        else $error("integrity jam not on collision output");

    property p_fiber;
        fiber_mode_pin |=> fiber_mode;
    endproperty
    a_fiber: assert property (p_fiber)
        else $error("fiber mode pin ignored");

    property p_status_wr;
        (mgmt_wr_en && hit(mgmt_addr, PSF_ADDR_STATUS)) |=> $stable(ctrl_reg);
    endproperty
    a_status_wr: assert property (p_status_wr)
        else $error("status write changed control");

    c_sticky_read: cover property (flag_bus.flags[PSF_ST_DISC] ##1 rd_status);
    c_soft_reset: cover property (soft_rst);
    c_pkt_code: cover property (mii_rx_error && mii_rx_nibble == PSF_CODE_PKT);
endmodule : psf_phy_regs
`default_nettype wire

// file: src/psf_stretch.sv
// Stretches three status outputs to a minimum length
`timescale 1ns/1ps
`default_nettype none
module psf_stretch
    import psf_pkg::*;
#(
    parameter int CYCLES = PSF_STRETCH_CYC
) (
    input  wire logic       core_clk,
    input  wire logic       rst_b,
    input  wire logic       enable,
    input  wire logic [2:0] din,
    output logic      [2:0] dout
);
    localparam logic [PSF_STR_W-1:0] LOAD = PSF_STR_W'(CYCLES - 1);
    logic [PSF_STR_W-1:0] cnt_reg [3];

    // ----------------------------------------
    // One hold counter per output
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 3; i++) begin
                cnt_reg[i] <= '0;
            end
            dout <= 3'h0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (!enable) begin
                    cnt_reg[i] <= '0;
                    dout[i]    <= din[i];
                end else if (din[i]) begin
                    cnt_reg[i] <= LOAD;
                    dout[i]    <= 1'b1;
                end else begin
                    cnt_reg[i] <= (cnt_reg[i] != '0) ? cnt_reg[i] - 1'b1 : cnt_reg[i];
                    dout[i]    <= (cnt_reg[i] != '0);
                end
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_stretch_hold;
        @(posedge core_clk) disable iff (!rst_b)
        (enable && din[0]) ##1 (enable && !din[0]) |-> dout[0];
    endproperty
    a_stretch_hold: assert property (p_stretch_hold)
        else $error("stretched output dropped early");
endmodule : psf_stretch
`default_nettype wire

// file: tb/psf_mgmt_station.sv
// Management station model issuing register reads and writes
`timescale 1ns/1ps
`default_nettype none
module psf_mgmt_station (
    input  wire logic        core_clk,
    output logic      [4:0]  mgmt_addr,
    output logic             mgmt_wr_en,
    output logic             mgmt_rd_en,
    output logic      [15:0] mgmt_wdata,
    input  wire logic [15:0] mgmt_rdata
);
    initial begin
        mgmt_addr  = 5'h00;
        mgmt_wr_en = 1'b0;
        mgmt_rd_en = 1'b0;
        mgmt_wdata = 16'h0000;
    end
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge core_clk);
        mgmt_addr  <= a;
        mgmt_wdata <= d;
        mgmt_wr_en <= 1'b1;
        @(posedge core_clk);
        mgmt_wr_en <= 1'b0;
        mgmt_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge core_clk);
        mgmt_addr  <= a;
        mgmt_rd_en <= 1'b1;
        @(posedge core_clk);
        mgmt_rd_en <= 1'b0;
        @(posedge core_clk);
        d = mgmt_rdata;
    endtask : rd
endmodule : psf_mgmt_station
`default_nettype wire

// file: tb/test_psf_phy_regs.sv
// Self-checking bench for the vendor status and fast-mode control registers
`timescale 1ns/1ps
`default_nettype none
`define CK(a, b) begin cmp_count++; if ((a) !== (b)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module test_psf_phy_regs
    import psf_pkg::*;
;
    typedef struct packed { logic [15:0] wd; logic pin; logic [8:0] ex; } psf_row_t;
    logic        core_clk, rst_b, mgmt_wr_en, mgmt_rd_en, mgmt_soft_reset, speed_100, sfd_missing_evt;
    logic        manchester_viol_evt, polarity_reversed, autopolarity_off, disconnect_evt, lock_lost_evt;
    logic        false_carrier_evt, jam_forced_evt, fast_xcvr_ok, slow_xcvr_ok, rx_err_in, link_fault_in;
    logic        scrambler_locked, mii_rx_error, polarity_correct, tx_pos_in, tx_neg_in, twisted_pair_pos;
    logic        twisted_pair_neg, led_flash_pin, led_flash_on, carrier_sense_sel_pin, rx_active, tx_active;
    logic        mii_carrier_sense_out, col_in, carrier_jam_in, collision_carrier_out, codec_bypass_pin;
    logic        codec_bypass, aligner_bypass, scrambler_bypass_pin, scrambler_bypass, carrier_integrity_pin;
    logic        carrier_integrity_en, far_fault_en, fiber_mode_pin, fiber_mode, factory_reset_a, factory_reset_b;
    logic [2:0]  status_in, status_out;
    logic [3:0]  rx_nibble_in, mii_rx_nibble;
    logic [4:0]  mgmt_addr;
    logic [15:0] mgmt_wdata, mgmt_rdata, rv;
    int          bad_count, cmp_count, sr_count;
    wire  [8:0]  ov = {factory_reset_a, factory_reset_b, led_flash_on, codec_bypass, aligner_bypass,
                       scrambler_bypass, carrier_integrity_en, far_fault_en, fiber_mode};
    psf_row_t    rows [10] = '{'{16'h5000, 1'b0, 9'h100}, '{16'h3000, 1'b0, 9'h080}, '{16'h1800, 1'b0, 9'h040},
        '{16'h1040, 1'b0, 9'h020}, '{16'h1020, 1'b0, 9'h010}, '{16'h1010, 1'b0, 9'h008},
        '{16'h1008, 1'b0, 9'h004}, '{16'h1002, 1'b0, 9'h002}, '{16'h1001, 1'b0, 9'h001}, '{16'h1000, 1'b1, 9'h06D}};
    psf_mgmt_station mgmt (.core_clk, .mgmt_addr, .mgmt_wr_en, .mgmt_rd_en, .mgmt_wdata, .mgmt_rdata);
    psf_phy_regs #(.STRETCH_CYCLES(8)) dut (.*);
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (mgmt_soft_reset === 1'b1) sr_count++;
    initial begin
        #100000;
        bad_count++;
        close_out();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {speed_100, sfd_missing_evt, manchester_viol_evt, polarity_reversed, autopolarity_off, disconnect_evt,
         lock_lost_evt, false_carrier_evt, jam_forced_evt, fast_xcvr_ok, slow_xcvr_ok, rx_nibble_in, rx_err_in,
         link_fault_in, scrambler_locked, tx_pos_in, tx_neg_in, led_flash_pin, carrier_sense_sel_pin, rx_active,
         tx_active, col_in, carrier_jam_in, status_in, codec_bypass_pin, scrambler_bypass_pin,
         carrier_integrity_pin, fiber_mode_pin} = '0;
        rst_b = 1'b0;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        mgmt.rd(PSF_ADDR_CTRL, rv);
        `CK(rv, PSF_CTRL_RST)
        mgmt.rd(5'h1E, rv);
        `CK(rv, 16'h0000)
        foreach (rows[i]) begin
            @(posedge core_clk) {led_flash_pin, codec_bypass_pin, scrambler_bypass_pin, carrier_integrity_pin,
                fiber_mode_pin} <= {5{rows[i].pin}};
            mgmt.wr(PSF_ADDR_CTRL, rows[i].wd);
            tick(2);
            `CK(ov, rows[i].ex)
            mgmt.rd(PSF_ADDR_CTRL, rv);
            `CK(rv, rows[i].wd)
        end
        @(posedge core_clk) {tx_pos_in, tx_neg_in, tx_active, led_flash_pin, codec_bypass_pin, scrambler_bypass_pin,
            carrier_integrity_pin, fiber_mode_pin} <= 8'hA0;
        mgmt.wr(PSF_ADDR_CTRL, 16'h0000);
        tick(2);
        `CK({twisted_pair_pos, twisted_pair_neg, mii_carrier_sense_out}, 3'b011)
        mgmt.wr(PSF_ADDR_CTRL, 16'h140C);
        tick(2);
        `CK({twisted_pair_pos, twisted_pair_neg, mii_carrier_sense_out}, 3'b100)
        @(posedge core_clk) carrier_jam_in <= 1'b1;
        tick(2);
        `CK(collision_carrier_out, 1'b1)
        @(posedge core_clk) {speed_100, rx_err_in, link_fault_in, rx_nibble_in, carrier_jam_in} <= 8'hEA;
        mgmt.wr(PSF_ADDR_CTRL, 16'h1300);
        tick(2);
        `CK({mii_rx_error, mii_rx_nibble}, {1'b1, PSF_CODE_LINK})
        @(posedge core_clk) link_fault_in <= 1'b0;
        tick(2);
        `CK(mii_rx_nibble, PSF_CODE_PKT)
        @(posedge core_clk) {sfd_missing_evt, disconnect_evt, lock_lost_evt, false_carrier_evt, jam_forced_evt,
            rx_err_in} <= 6'h3E;
        @(posedge core_clk) {sfd_missing_evt, disconnect_evt, lock_lost_evt, false_carrier_evt,
            jam_forced_evt} <= 5'h00;
        mgmt.wr(PSF_ADDR_STATUS, 16'hFFFF);
        mgmt.rd(PSF_ADDR_STATUS, rv);
        `CK(rv, 16'h003C)
        fork
            mgmt.rd(PSF_ADDR_STATUS, rv);
            @(posedge core_clk) disconnect_evt <= 1'b1;
        join
        disconnect_evt <= 1'b0;
        `CK(rv, 16'h0000)
        mgmt.rd(PSF_ADDR_STATUS, rv);
        `CK(rv, 16'h0020)
        mgmt.wr(PSF_ADDR_CTRL, 16'h1080);
        @(posedge core_clk) status_in <= 3'h7;
        @(posedge core_clk) status_in <= 3'h0;
        tick(4);
        `CK(status_out, 3'h7)
        tick(6);
        `CK(status_out, 3'h0)
        @(posedge core_clk) {speed_100, sfd_missing_evt, manchester_viol_evt, disconnect_evt, polarity_reversed,
            fast_xcvr_ok, slow_xcvr_ok} <= 7'h3F;
        @(posedge core_clk) {sfd_missing_evt, manchester_viol_evt, disconnect_evt} <= 3'b000;
        mgmt.rd(PSF_ADDR_STATUS, rv);
        `CK(rv, 16'h01C3)
        `CK(polarity_correct, 1'b1)
        @(posedge core_clk) {sfd_missing_evt, autopolarity_off} <= 2'b11;
        @(posedge core_clk) sfd_missing_evt <= 1'b0;
        mgmt.wr(PSF_ADDR_CTRL, 16'h1FFF);
        mgmt.wr(PSF_ADDR_CTRL, 16'h8000);
        tick(2);
        `CK(ov, 9'h000)
        `CK(sr_count, 1)
        mgmt.rd(PSF_ADDR_CTRL, rv);
        `CK(rv, PSF_CTRL_RST)
        mgmt.rd(PSF_ADDR_STATUS, rv);
        `CK(rv, 16'h0003)
        `CK(polarity_correct, 1'b0)
        close_out();
    end
endmodule : test_psf_phy_regs
`default_nettype wire
